// file: include/tsc_regs_defs.svh
// register indices, field positions, masks and reset values of the terminal status and config bank
`ifndef TSC_REGS_DEFS_SVH
`define TSC_REGS_DEFS_SVH

// word indices; byte address is four times the index
`define TSC_IDX_BIT_WORD    6'h0f
`define TSC_IDX_CONFIG_SIX  6'h18
`define TSC_IDX_CONFIG_SEV  6'h19
`define TSC_IDX_FLAG_COND   6'h1b
`define TSC_IDX_INT_STATUS  6'h20
`define TSC_IDX_INT_MASK    6'h21

// writable bits; reserved positions read as zero
`define TSC_CONFIG_SIX_WMASK 16'hfff7
`define TSC_CONFIG_SEV_WMASK 16'hfc1f

// reset values
`define TSC_CONFIG_SIX_RESET 16'h0000
`define TSC_CONFIG_SEV_RESET 16'h0000
`define TSC_GP_FLAG_RESET    8'h00
`define TSC_INT_STATUS_RESET 16'h0000
`define TSC_INT_MASK_RESET   16'h0000

// flag register write fields
`define TSC_FLAG_CLR_HI  15
`define TSC_FLAG_CLR_LO  8
`define TSC_FLAG_SET_HI  7
`define TSC_FLAG_SET_LO  0

// condition word constant top bit
`define TSC_COND_TOP_BIT 1'h1
`define TSC_COND_OFFLINE 16'h0000

`endif

// file: include/tsc_pkg.sv
// types shared by the terminal status and config register bank
package tsc_pkg;

  typedef struct packed {
    logic       ebc_enable;
    logic       cpu_access_enh;
    logic       stack_inc_eom;
    logic       gcb_enable;
    logic [2:0] gcb_size;
    logic       isq_drop_invalid;
    logic       isq_drop_valid;
    logic       isq_enable;
    logic       rt_addr_src;
    logic       emm_enable;
    logic       rsvd;
    logic       reg64_enable;
    logic [1:0] clk_sel;
  } tsc_cfg_six_type;

  typedef struct packed {
    logic [5:0] mm_base;
    logic [4:0] rsvd;
    logic       rt_halt;
    logic       resp_1553b;
    logic       ttag_sync;
    logic       wdt_enable;
    logic       mc_reset_sel;
  } tsc_cfg_sev_type;

  typedef struct packed {
    logic [1:0] retry;
    logic       bad_message;
    logic       status_set;
    logic       good_block;
    logic       format_error;
    logic       no_response;
  } tsc_bc_cond_type;

  typedef struct packed {
    tsc_cfg_six_type cfg_six;
    tsc_cfg_sev_type cfg_sev;
    logic [7:0]      gp_flags;
    logic [15:0]     int_status;
    logic [15:0]     int_mask;
    logic [15:0]     fault_prev;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            irq;
  } tsc_state_type;

endpackage : tsc_pkg

// file: src/tsc_regs.sv
// terminal self-test, configuration and bus-controller flag/condition registers behind an APB slave
`timescale 1ns/100ps
`include "tsc_regs_defs.svh"

module tsc_regs
  import tsc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              CLK_SYS_IN,
  input  wire logic              NRST_IN,
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire logic [ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]       PWDATA_IN,
  output logic      [31:0]       PRDATA_OUT,
  output logic                   PREADY_OUT,
  output logic                   PSLVERR_OUT,
  input  wire logic [15:0]       BIT_FAULT_IN,
  input  wire tsc_bc_cond_type   BC_COND_IN,
  input  wire logic              BC_ONLINE_IN,
  input  wire logic              CMP_LOAD_IN,
  input  wire logic              CMP_EQUAL_IN,
  input  wire logic              CMP_LESS_IN,
  output tsc_cfg_six_type        CONFIG_SIX_OUT,
  output tsc_cfg_sev_type        CONFIG_SEVEN_OUT,
  output logic      [7:0]        GP_FLAG_OUT,
  output logic                   IRQ_OUT
);

  localparam tsc_state_type RESET_STATE = '{
    cfg_six:    tsc_cfg_six_type'(`TSC_CONFIG_SIX_RESET),
    cfg_sev:    tsc_cfg_sev_type'(`TSC_CONFIG_SEV_RESET),
    gp_flags:   `TSC_GP_FLAG_RESET,
    int_status: `TSC_INT_STATUS_RESET,
    int_mask:   `TSC_INT_MASK_RESET,
    fault_prev: 16'h0000,
    prdata:     32'h0000_0000,
    pready:     1'h0,
    pslverr:    1'h0,
    irq:        1'h0
  };

  tsc_state_type st;
  tsc_state_type next_st;

  logic        setup;
  logic        commit;
  logic        online;
  logic [15:0] wdata16;
  logic [7:0]  flag_clr;
  logic [7:0]  flag_set;
  logic [15:0] fault_rise;
  logic [15:0] cond_word;

  // word index match; low two address bits are ignored as on any word-wide APB slave
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : reg_hit

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    reg_mapped = reg_hit(addr, `TSC_IDX_BIT_WORD) || reg_hit(addr, `TSC_IDX_CONFIG_SIX)
              || reg_hit(addr, `TSC_IDX_CONFIG_SEV) || reg_hit(addr, `TSC_IDX_FLAG_COND)
              || reg_hit(addr, `TSC_IDX_INT_STATUS) || reg_hit(addr, `TSC_IDX_INT_MASK);
  endfunction : reg_mapped

  assign setup      = PSEL_IN && !PENABLE_IN;
  // pready is only ever high in the access phase, so this is the one completing edge
  assign commit     = PSEL_IN && PENABLE_IN && st.pready && PWRITE_IN;
  assign online     = st.cfg_six.ebc_enable && BC_ONLINE_IN;
  assign wdata16    = PWDATA_IN[15:0];
  assign flag_clr   = PWDATA_IN[`TSC_FLAG_CLR_HI:`TSC_FLAG_CLR_LO];
  assign flag_set   = PWDATA_IN[`TSC_FLAG_SET_HI:`TSC_FLAG_SET_LO];
  assign fault_rise = BIT_FAULT_IN & ~st.fault_prev;

  // condition word; flags 1 and 0 double as the equal and less-than compare results
  always_comb
  begin
    if (online)
    begin
      cond_word = {`TSC_COND_TOP_BIT, BC_COND_IN.retry, BC_COND_IN.bad_message,
                   BC_COND_IN.status_set, BC_COND_IN.good_block, BC_COND_IN.format_error,
                   BC_COND_IN.no_response, st.gp_flags[7:2], st.gp_flags[1], st.gp_flags[0]};
    end
    else
    begin
      cond_word = `TSC_COND_OFFLINE;
    end
  end

  always_comb
  begin
    next_st = st;

    // engine compare result lands first so a host write in the same cycle overrides it
    if (CMP_LOAD_IN)
    begin
      next_st.gp_flags[1] = CMP_EQUAL_IN;
      next_st.gp_flags[0] = CMP_LESS_IN;
    end

    // fault edges are sticky until software writes a one back
    next_st.fault_prev = BIT_FAULT_IN;
    if (commit && reg_hit(PADDR_IN, `TSC_IDX_INT_STATUS))
    begin
      next_st.int_status = st.int_status & ~wdata16;
    end
    next_st.int_status = next_st.int_status | fault_rise;

    if (commit)
    begin
      if (reg_hit(PADDR_IN, `TSC_IDX_CONFIG_SIX))
      begin
        next_st.cfg_six = tsc_cfg_six_type'(wdata16 & `TSC_CONFIG_SIX_WMASK);
      end
      if (reg_hit(PADDR_IN, `TSC_IDX_CONFIG_SEV))
      begin
        next_st.cfg_sev = tsc_cfg_sev_type'(wdata16 & `TSC_CONFIG_SEV_WMASK);
      end
      if (reg_hit(PADDR_IN, `TSC_IDX_FLAG_COND))
      begin
        // clear is applied after set, so a bit asked for both ends up zero
        next_st.gp_flags = (next_st.gp_flags | flag_set) & ~flag_clr;
      end
      if (reg_hit(PADDR_IN, `TSC_IDX_INT_MASK))
      begin
        next_st.int_mask = wdata16;
      end
    end

    // no wait state: answer is prepared on the setup edge and offered in the access phase
    next_st.pready  = setup;
    next_st.pslverr = 1'h0;
    next_st.prdata  = 32'h0000_0000;
    if (setup)
    begin
      if (!reg_mapped(PADDR_IN))
      begin
        next_st.pslverr = 1'h1;
      end
      else if (PWRITE_IN && reg_hit(PADDR_IN, `TSC_IDX_BIT_WORD))
      begin
        next_st.pslverr = 1'h1;
      end
      else if (!PWRITE_IN)
      begin
        if (reg_hit(PADDR_IN, `TSC_IDX_BIT_WORD))
        begin
          next_st.prdata = {16'h0000, BIT_FAULT_IN};
        end
        else if (reg_hit(PADDR_IN, `TSC_IDX_CONFIG_SIX))
        begin
          next_st.prdata = {16'h0000, 16'(st.cfg_six)};
        end
        else if (reg_hit(PADDR_IN, `TSC_IDX_CONFIG_SEV))
        begin
          next_st.prdata = {16'h0000, 16'(st.cfg_sev)};
        end
        else if (reg_hit(PADDR_IN, `TSC_IDX_FLAG_COND))
        begin
          next_st.prdata = {16'h0000, cond_word};
        end
        else if (reg_hit(PADDR_IN, `TSC_IDX_INT_STATUS))
        begin
          next_st.prdata = {16'h0000, st.int_status};
        end
        else
        begin
          next_st.prdata = {16'h0000, st.int_mask};
        end
      end
    end

    next_st.irq = |(next_st.int_status & next_st.int_mask);
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!NRST_IN)
    begin
      st <= RESET_STATE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign PRDATA_OUT       = st.prdata;
  assign PREADY_OUT       = st.pready;
  assign PSLVERR_OUT      = st.pslverr;
  assign CONFIG_SIX_OUT   = st.cfg_six;
  assign CONFIG_SEVEN_OUT = st.cfg_sev;
  assign GP_FLAG_OUT      = st.gp_flags;
  assign IRQ_OUT          = st.irq;

  // checking helpers
  logic [7:0]  chk_set_only;
  logic [7:0]  chk_flags;
  logic        chk_wr_flag;
  logic        chk_rd_cond;
  logic        chk_rd_bit;
  logic        chk_wr_six;
  logic        chk_wr_sev;
  logic [15:0] chk_six_exp;
  logic [15:0] chk_sev_exp;

  assign chk_set_only = flag_set & ~flag_clr;
  assign chk_flags    = st.gp_flags;
  assign chk_wr_flag  = commit && reg_hit(PADDR_IN, `TSC_IDX_FLAG_COND) && !CMP_LOAD_IN;
  assign chk_rd_cond  = setup && !PWRITE_IN && reg_hit(PADDR_IN, `TSC_IDX_FLAG_COND);
  assign chk_rd_bit   = setup && !PWRITE_IN && reg_hit(PADDR_IN, `TSC_IDX_BIT_WORD);
  assign chk_wr_six   = commit && reg_hit(PADDR_IN, `TSC_IDX_CONFIG_SIX);
  assign chk_wr_sev   = commit && reg_hit(PADDR_IN, `TSC_IDX_CONFIG_SEV);
  assign chk_six_exp  = wdata16 & `TSC_CONFIG_SIX_WMASK;
  assign chk_sev_exp  = wdata16 & `TSC_CONFIG_SEV_WMASK;

  default clocking chk_cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!NRST_IN);

  chk_flag_clear_bits: assert property (
    commit && reg_hit(PADDR_IN, `TSC_IDX_FLAG_COND) |=> (GP_FLAG_OUT & $past(flag_clr)) == 8'h00)
    else $error("flag written as clear is still set");

  chk_flag_set_bits: assert property (
    chk_wr_flag |=> (GP_FLAG_OUT & $past(chk_set_only)) == $past(chk_set_only))
    else $error("flag written as set is not set");

  chk_flag_untouched: assert property (
    chk_wr_flag |=> (GP_FLAG_OUT & ~$past(flag_clr) & ~$past(flag_set))
                    == ($past(chk_flags) & ~$past(flag_clr) & ~$past(flag_set)))
    else $error("flag not named by the write changed");

  chk_cond_read_word: assert property (
    chk_rd_cond && online |=> PRDATA_OUT[15] && PRDATA_OUT[7:2] == $past(chk_flags[7:2])
                              && PREADY_OUT ##1 !PREADY_OUT)
    else $error("condition word top bit or flags wrong");

  chk_cond_cmp_bits: assert property (
    chk_rd_cond && online |=> PRDATA_OUT[1:0] == $past(chk_flags[1:0]))
    else $error("compare bits of condition word wrong");

  chk_cond_offline_zero: assert property (
    chk_rd_cond && !online |=> PRDATA_OUT == 32'h0000_0000 && !PSLVERR_OUT)
    else $error("condition word not zero while offline");

  chk_bit_word_read: assert property (
    chk_rd_bit |=> PRDATA_OUT == {16'h0000, $past(BIT_FAULT_IN)} && PREADY_OUT)
    else $error("self-test word read does not match faults");

  chk_bit_word_ro: assert property (
    setup && PWRITE_IN && reg_hit(PADDR_IN, `TSC_IDX_BIT_WORD) |=> PSLVERR_OUT && PREADY_OUT)
    else $error("write to self-test word not refused");

  chk_config_six_store: assert property (
    chk_wr_six |=> 16'(CONFIG_SIX_OUT) == $past(chk_six_exp) ##1 16'(CONFIG_SIX_OUT) == $past(chk_six_exp, 2))
    else $error("config six did not store written value");

  chk_config_six_rsvd: assert property (
    CONFIG_SIX_OUT.rsvd == 1'h0)
    else $error("config six reserved bit set");

  chk_config_sev_store: assert property (
    chk_wr_sev |=> 16'(CONFIG_SEVEN_OUT) == $past(chk_sev_exp))
    else $error("config seven did not store written value");

  chk_config_sev_rsvd: assert property (
    CONFIG_SEVEN_OUT.rsvd == 5'h00)
    else $error("config seven reserved bits set");

  chk_irq_level: assert property (
    IRQ_OUT == |(st.int_status & st.int_mask))
    else $error("interrupt output disagrees with status and mask");

  // sampled reset gates these: at the release edge the state still moves to its reset value
  chk_fault_sticky: assert property (
    NRST_IN && fault_rise != 16'h0000 |=> (st.int_status & $past(fault_rise)) == $past(fault_rise))
    else $error("fault edge not latched");

  chk_six_hold: assert property (
    NRST_IN && !chk_wr_six |=> $stable(CONFIG_SIX_OUT))
    else $error("config six changed without a write");

  chk_seven_hold: assert property (
    NRST_IN && !chk_wr_sev |=> $stable(CONFIG_SEVEN_OUT))
    else $error("config seven changed without a write");

  chk_flags_hold: assert property (
    NRST_IN && !CMP_LOAD_IN && !(commit && reg_hit(PADDR_IN, `TSC_IDX_FLAG_COND)) |=> $stable(GP_FLAG_OUT))
    else $error("flags changed without a write or compare load");

  // a completed transfer must free the bus in the very next cycle
  chk_ready_one_cycle: assert property (
    PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held for more than one cycle");

  chk_idle_data_zero: assert property (
    !PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000 && !PSLVERR_OUT)
    else $error("read data or error shown outside a transfer");

  chk_unmapped_refused: assert property (
    setup && !reg_mapped(PADDR_IN) |=> PSLVERR_OUT && PREADY_OUT && PRDATA_OUT == 32'h0000_0000)
    else $error("unmapped index not refused");

  chk_mapped_no_error: assert property (
    setup && reg_mapped(PADDR_IN) && !(PWRITE_IN && reg_hit(PADDR_IN, `TSC_IDX_BIT_WORD)) |=> !PSLVERR_OUT)
    else $error("mapped register answered with an error");

  chk_compare_load: assert property (
    CMP_LOAD_IN && !(commit && reg_hit(PADDR_IN, `TSC_IDX_FLAG_COND))
    |=> GP_FLAG_OUT[1] == $past(CMP_EQUAL_IN) && GP_FLAG_OUT[0] == $past(CMP_LESS_IN))
    else $error("compare results not loaded into flags 1 and 0");

  chk_cond_fields: assert property (
    chk_rd_cond && online |=> PRDATA_OUT[14:8] == 7'($past(BC_COND_IN)))
    else $error("condition fields of condition word wrong");

  // a fault edge in the same cycle as the clear must survive it
  chk_status_w1c: assert property (
    commit && reg_hit(PADDR_IN, `TSC_IDX_INT_STATUS)
    |=> (st.int_status & $past(wdata16) & ~$past(fault_rise)) == 16'h0000)
    else $error("interrupt status bit written with one not cleared");

  cov_flag_both: cover property (chk_wr_flag && (flag_set & flag_clr) != 8'h00);
  cov_cond_online: cover property (chk_rd_cond && online);
  cov_cond_offline: cover property (chk_rd_cond && !online);
  cov_irq_rise: cover property (!IRQ_OUT ##1 IRQ_OUT);
  cov_load_with_write: cover property (CMP_LOAD_IN && commit && reg_hit(PADDR_IN, `TSC_IDX_FLAG_COND));

endmodule : tsc_regs

// file: bench/tsc_host_model.sv
// host processor model: apb master for the register bank
`timescale 1ns/100ps
module tsc_host_model
(
  input  wire logic        clk_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h00000000;
  end

  // request held until pready is seen high; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_out   <= 1'b1;
    pwrite_out <= wr;
    paddr_out  <= {idx, 2'b00};
    pwdata_out <= {16'h0000, wd};
    @(posedge clk_in);
    penable_out <= 1'b1;
    do
      @(posedge clk_in);
    while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    // released lines flip so a stale value never looks valid
    paddr_out   <= ~paddr_out;
    pwdata_out  <= ~pwdata_out;
  endtask : xfer
endmodule : tsc_host_model

// file: bench/testbench.sv
// self-checking bench for the terminal status and config register bank
`timescale 1ns/100ps
module testbench;
  import tsc_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [5:0]  idx;
    logic [15:0] wd;
    logic [15:0] rd;
    logic        err;
    logic        irq;
  } tsc_row_type;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fault = 16'ha5c3;
  logic online = 1'b1;
  logic load = 1'b0;
  logic eq = 1'b0;
  logic less = 1'b0;
  logic err;
  logic [7:0] flags;
  tsc_cfg_six_type six;
  tsc_cfg_sev_type sev;
  tsc_bc_cond_type cond = 7'b1010101;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  tsc_row_type rows [16] = '{
    '{1'b0, 6'h20, 16'h0000, 16'ha5c3, 1'b0, 1'b0},
    '{1'b1, 6'h21, 16'h0001, 16'h0000, 1'b0, 1'b1},
    '{1'b1, 6'h20, 16'h0001, 16'h0000, 1'b0, 1'b0},
    '{1'b0, 6'h20, 16'h0000, 16'ha5c2, 1'b0, 1'b0},
    '{1'b1, 6'h18, 16'hffff, 16'h0000, 1'b0, 1'b0},
    '{1'b0, 6'h18, 16'h0000, 16'hfff7, 1'b0, 1'b0},
    '{1'b1, 6'h19, 16'hffff, 16'h0000, 1'b0, 1'b0},
    '{1'b0, 6'h19, 16'h0000, 16'hfc1f, 1'b0, 1'b0},
    '{1'b0, 6'h0f, 16'h0000, 16'ha5c3, 1'b0, 1'b0},
    '{1'b1, 6'h0f, 16'h1234, 16'h0000, 1'b1, 1'b0},
    '{1'b0, 6'h05, 16'h0000, 16'h0000, 1'b1, 1'b0},
    '{1'b1, 6'h1b, 16'h00ff, 16'h0000, 1'b0, 1'b0},
    '{1'b0, 6'h1b, 16'h0000, 16'hd5ff, 1'b0, 1'b0},
    '{1'b1, 6'h1b, 16'h8100, 16'h0000, 1'b0, 1'b0},
    '{1'b0, 6'h1b, 16'h0000, 16'hd57e, 1'b0, 1'b0},
    '{1'b1, 6'h1b, 16'h0202, 16'h0000, 1'b0, 1'b0}};

  always #12.5 clk = ~clk;

  tsc_host_model host_i (.clk_in(clk), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

  tsc_regs tsc_regs_i (.CLK_SYS_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .BIT_FAULT_IN(fault), .BC_COND_IN(cond), .BC_ONLINE_IN(online),
    .CMP_LOAD_IN(load), .CMP_EQUAL_IN(eq), .CMP_LESS_IN(less), .CONFIG_SIX_OUT(six),
    .CONFIG_SEVEN_OUT(sev), .GP_FLAG_OUT(flags), .IRQ_OUT(irq));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp);
    host_i.xfer(1'b0, idx, 16'h0000, rd, err);
    chk("read data", rd, {16'h0000, exp});
  endtask : rd_chk

  // long enough for all transfers; a hang ends the run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk("flags after reset", flags, 8'h00);
    chk("config six after reset", six, 16'h0000);
    foreach (rows[i])
    begin
      host_i.xfer(rows[i].wr, rows[i].idx, rows[i].wd, rd, err);
      #1;
      if (!rows[i].wr)
        chk("row data", rd, {16'h0000, rows[i].rd});
      chk("row error", err, rows[i].err);
      chk("row irq", irq, rows[i].irq);
    end
    chk("config six out", six, 16'hfff7);
    chk("config seven out", sev, 16'hfc1f);
    $display("table test done");
    rd_chk(6'h1b, 16'hd57c);
    host_i.xfer(1'b1, 6'h18, 16'h7fff, rd, err);
    rd_chk(6'h1b, 16'h0000);
    host_i.xfer(1'b1, 6'h18, 16'hffff, rd, err);
    @(posedge clk);
    online <= 1'b0;
    rd_chk(6'h1b, 16'h0000);
    $display("offline test done");
    @(posedge clk);
    online <= 1'b1;
    eq <= 1'b1;
    less <= 1'b1;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    #1 chk("compare flags", flags, 8'h7f);
    rd_chk(6'h1b, 16'hd57f);
    eq <= 1'b0;
    less <= 1'b0;
    // compare load lands on the same edge as a host write setting flag 1
    fork
      host_i.xfer(1'b1, 6'h1b, 16'h0002, rd, err);
      begin
        repeat (2) @(posedge clk);
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
      end
    join
    #1 chk("host write beats compare load", flags, 8'h7e);
    $display("compare test done");
    @(posedge clk);
    fault <= 16'h0000;
    @(posedge clk);
    fault <= 16'h0001;
    repeat (2) @(posedge clk);
    #1 chk("irq on new fault", irq, 1'b1);
    host_i.xfer(1'b1, 6'h21, 16'h0000, rd, err);
    #1 chk("irq masked", irq, 1'b0);
    $display("interrupt test done");
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    #1 chk("flags after second reset", flags, 8'h00);
    chk("config seven after reset", sev, 16'h0000);
    chk("irq after reset", irq, 1'b0);
    $display("reset test done");
    finish_test();
  end
endmodule : testbench
